//--- core/hpc_consts.svh
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// Register byte offsets
`define HPC_OFS_SP_MAX_POWER 8'h0C
`define HPC_OFS_BP_MAX_POWER 8'h0D
`define HPC_OFS_SP_CTRL_CURRENT 8'h0E
`define HPC_OFS_BP_CTRL_CURRENT 8'h0F
`define HPC_OFS_SETTLE_TIME 8'h10
`define HPC_OFS_LANG_UPPER 8'h11
`define HPC_OFS_LANG_LOWER 8'h12
`define HPC_OFS_TEXT_LENGTH 8'h13
`define HPC_NUM_REGS 8

// Maker text byte area
`define HPC_TEXT_BASE 8'h16
`define HPC_TEXT_LAST 8'h53

// Reset values
`define HPC_RST_CTRL_CURRENT 8'h32
`define HPC_RST_ZERO 8'h00

// Units and limits
`define HPC_MA_PER_UNIT 9'h002
`define HPC_MAX_TEXT_CHARS 8'h1F
`define HPC_MAX_UNITS_100MA 8'h32
`define HPC_DESC_HEADER_BYTES 8'h02

// Timing: one settle interval in ms, clock in MHz
`define HPC_SETTLE_UNIT_MS 2
`define HPC_CLK_MHZ 125
`define HPC_TICK_CYCLES (`HPC_SETTLE_UNIT_MS * 1000 * `HPC_CLK_MHZ)

`endif

//--- core/hpc_pkg.sv
package hpc_pkg;

  typedef logic [7:0] hpc_byte_t;

  // Gray path: idle -> waiting -> good
  typedef enum logic [1:0] {
    HPC_SETTLE_IDLE = 2'h0,
    HPC_SETTLE_WAIT = 2'h1,
    HPC_SETTLE_GOOD = 2'h3
  } hpc_settle_state_t;

endpackage

//--- core/hpc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_settle_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic power_on,
  input wire logic power_off,
  input wire hpc_pkg::hpc_byte_t settle_count,
  output logic power_good,
  output logic busy
);

  hpc_pkg::hpc_settle_state_t state_q;
  hpc_pkg::hpc_byte_t left_q;

  // Sequence: start loads the interval count, ticks walk it down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hpc_pkg::HPC_SETTLE_IDLE;
      left_q <= `HPC_RST_ZERO;
    end else if (power_off) begin
      state_q <= hpc_pkg::HPC_SETTLE_IDLE;
      left_q <= `HPC_RST_ZERO;
    end else if (power_on) begin
      left_q <= settle_count;
      // A zero count means power is stable at once
      if (settle_count == `HPC_RST_ZERO) begin
        state_q <= hpc_pkg::HPC_SETTLE_GOOD;
      end else begin
        state_q <= hpc_pkg::HPC_SETTLE_WAIT; // [RQ8]
      end
    end else begin
      case (state_q)
        hpc_pkg::HPC_SETTLE_WAIT: begin
          if (tick) begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              state_q <= hpc_pkg::HPC_SETTLE_GOOD; // [RQ8]
            end
          end
        end
        hpc_pkg::HPC_SETTLE_IDLE: state_q <= hpc_pkg::HPC_SETTLE_IDLE;
        hpc_pkg::HPC_SETTLE_GOOD: state_q <= hpc_pkg::HPC_SETTLE_GOOD;
        default: state_q <= hpc_pkg::HPC_SETTLE_IDLE;
      endcase
    end
  end

  // Status straight from the state register
  assign power_good = (state_q == hpc_pkg::HPC_SETTLE_GOOD);
  assign busy = (state_q == hpc_pkg::HPC_SETTLE_WAIT);

endmodule

`default_nettype wire

//--- core/hpc_text_packer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_text_packer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic byte_valid,
  input wire logic [5:0] byte_offset,
  input wire hpc_pkg::hpc_byte_t byte_data,
  output logic unit_valid,
  output logic [15:0] unit_data,
  output logic [4:0] unit_index,
  output logic pair_error
);

  hpc_pkg::hpc_byte_t low_q;
  logic [4:0] low_index_q;
  logic low_held_q;

  // Even offset holds the low byte until its partner arrives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= `HPC_RST_ZERO;
      low_index_q <= 5'h00;
      low_held_q <= 1'b0;
    end else if (byte_valid && !byte_offset[0]) begin
      low_q <= byte_data; // [RQ11]
      low_index_q <= byte_offset[5:1];
      low_held_q <= 1'b1;
    end else if (byte_valid) begin
      low_held_q <= 1'b0;
    end
  end

  // Odd offset closes the unit; a high byte without its low byte is dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_valid <= 1'b0;
      unit_data <= 16'h0000;
      unit_index <= 5'h00;
      pair_error <= 1'b0;
    end else begin
      unit_valid <= 1'b0;
      pair_error <= 1'b0;
      if (byte_valid && byte_offset[0]) begin
        if (low_held_q && (low_index_q == byte_offset[5:1])) begin
          unit_valid <= 1'b1;
          unit_data <= {byte_data, low_q}; // [RQ11]
          unit_index <= byte_offset[5:1];
        end else begin
          pair_error <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- core/hpc_power_string_regs.sv
// How it works
// [RQ1] The self-powered maximum power byte counts 2 mA steps and is reported as upstream draw.
// [RQ2] The configuring party folds board and zero-reporting compound peripheral current in.
// [RQ3] The configuring party keeps self-powered power and controller current at 100 mA or less.
// [RQ4] The bus-powered maximum power byte counts 2 mA steps of upstream draw in bus mode.
// [RQ5] The self-powered controller current byte counts 2 mA steps of silicon and board only.
// [RQ6] The self-powered controller current byte resets to 50, meaning 100 mA.
// [RQ7] The bus-powered controller current byte counts 2 mA steps and resets to 50.
// [RQ8] The settle byte counts 2 ms intervals from port power-on until power is stable.
// [RQ9] The language code is the upper byte register over the lower byte register.
// [RQ10] The configuring party keeps the maker text length at 31 characters or less.
// [RQ11] Text bytes pair into 16-bit units, low byte first at the lower address.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_power_string_regs #(
  parameter int TICK_CYCLES = `HPC_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire hpc_pkg::hpc_byte_t cfg_addr,
  input wire hpc_pkg::hpc_byte_t cfg_wr_data,
  output hpc_pkg::hpc_byte_t cfg_rd_data,
  output logic cfg_rd_valid,
  input wire logic self_power_pin,
  input wire logic port_power_on,
  input wire logic port_power_off,
  output logic port_power_good,
  output logic port_settle_busy,
  output hpc_pkg::hpc_byte_t max_power_units,
  output logic [8:0] max_power_ma,
  output logic [8:0] ctrl_current_ma,
  output hpc_pkg::hpc_byte_t settle_intervals,
  output logic [15:0] lang_code,
  output hpc_pkg::hpc_byte_t text_length,
  output hpc_pkg::hpc_byte_t text_desc_length,
  output logic text_unit_valid,
  output logic [15:0] text_unit,
  output logic [4:0] text_unit_index,
  output logic text_unit_beyond_len,
  output logic text_pair_error,
  output logic text_length_over,
  output logic sp_power_over
);

  localparam int TICK_LAST = TICK_CYCLES - 1;

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  logic pin_sync1_q;
  logic pin_sync2_q;
  logic [17:0] div_q;
  logic tick_q;
  hpc_pkg::hpc_byte_t regs_q [`HPC_NUM_REGS];
  logic text_byte_valid;
  logic [5:0] text_byte_offset;
  logic pk_valid;
  logic [15:0] pk_data;
  logic [4:0] pk_index;
  logic pk_error;
  hpc_pkg::hpc_byte_t clamped_len;
  logic [3:0] rd_idx;
  // Named register bytes and the mode-picked pair
  hpc_pkg::hpc_byte_t self_powered_max_power;
  hpc_pkg::hpc_byte_t bus_powered_max_power;
  hpc_pkg::hpc_byte_t self_powered_controller_current;
  hpc_pkg::hpc_byte_t bus_powered_controller_current;
  hpc_pkg::hpc_byte_t port_power_settle_time;
  hpc_pkg::hpc_byte_t language_code_upper;
  hpc_pkg::hpc_byte_t language_code_lower;
  hpc_pkg::hpc_byte_t maker_text_length;
  hpc_pkg::hpc_byte_t sel_max_power;
  hpc_pkg::hpc_byte_t sel_ctrl_current;

  // Register index for a mapped offset; shared by write and read paths
  function automatic logic [3:0] reg_index(input hpc_pkg::hpc_byte_t addr);
    logic [3:0] idx;
    idx = 4'hF;
    if (addr >= `HPC_OFS_SP_MAX_POWER && addr <= `HPC_OFS_TEXT_LENGTH) begin
      idx = 4'(addr - `HPC_OFS_SP_MAX_POWER);
    end
    return idx;
  endfunction

  // Reset value per register index
  function automatic hpc_pkg::hpc_byte_t reg_reset(input int idx);
    hpc_pkg::hpc_byte_t val;
    val = `HPC_RST_ZERO;
    if (idx == int'(`HPC_OFS_SP_CTRL_CURRENT - `HPC_OFS_SP_MAX_POWER) ||
        idx == int'(`HPC_OFS_BP_CTRL_CURRENT - `HPC_OFS_SP_MAX_POWER)) begin
      val = `HPC_RST_CTRL_CURRENT;
    end
    return val;
  endfunction

  // Byte count in 2 mA steps to milliamps
  function automatic logic [8:0] units_to_ma(input hpc_pkg::hpc_byte_t units);
    return 9'({1'b0, units} * `HPC_MA_PER_UNIT);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // Power mode strap is a pin, so it is synchronised first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
    end else begin
      pin_sync1_q <= self_power_pin;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // Settle interval divider, restarted on power-on so the first interval is whole
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 18'h00000;
      tick_q <= 1'b0;
    end else if (port_power_on) begin
      div_q <= 18'h00000;
      tick_q <= 1'b0;
    end else if (div_q == 18'(TICK_LAST)) begin
      div_q <= 18'h00000;
      tick_q <= 1'b1; // [RQ8]
    end else begin
      div_q <= div_q + 18'h00001;
      tick_q <= 1'b0;
    end
  end

  // One byte register per mapped offset
  generate
    for (genvar i = 0; i < `HPC_NUM_REGS; i++) begin : g_reg
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[i] <= reg_reset(i); // [RQ6] [RQ7]
        end else if (cfg_wr_en && reg_index(cfg_addr) == 4'(i)) begin
          regs_q[i] <= cfg_wr_data;
        end
      end
    end
  endgenerate

  // Slot of the addressed register; 4'hF marks an unmapped offset
  assign rd_idx = reg_index(cfg_addr);

  // Registered read; unmapped and text area offsets read as zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_data <= `HPC_RST_ZERO;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en) begin
        if (rd_idx != 4'hF) begin
          cfg_rd_data <= regs_q[rd_idx[2:0]];
        end else begin
          cfg_rd_data <= `HPC_RST_ZERO;
        end
      end
    end
  end

  // Writes into the text area feed the unit packer
  assign text_byte_valid = cfg_wr_en && (cfg_addr >= `HPC_TEXT_BASE) &&
                           (cfg_addr <= `HPC_TEXT_LAST);
  assign text_byte_offset = 6'(cfg_addr - `HPC_TEXT_BASE);

  hpc_text_packer u_packer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .byte_valid(text_byte_valid),
    .byte_offset(text_byte_offset),
    .byte_data(cfg_wr_data),
    .unit_valid(pk_valid),
    .unit_data(pk_data),
    .unit_index(pk_index),
    .pair_error(pk_error)
  );

  // Packed units handed on with a flag past the programmed length
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      text_unit_valid <= 1'b0;
      text_unit <= 16'h0000;
      text_unit_index <= 5'h00;
      text_unit_beyond_len <= 1'b0;
      text_pair_error <= 1'b0;
    end else begin
      text_unit_valid <= pk_valid;
      text_pair_error <= pk_error;
      if (pk_valid) begin
        text_unit <= pk_data; // [RQ11]
        text_unit_index <= pk_index;
        text_unit_beyond_len <= ({3'h0, pk_index} >= clamped_len);
      end
    end
  end

  hpc_settle_timer u_settle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .power_on(port_power_on),
    .power_off(port_power_off),
    .settle_count(port_power_settle_time),
    .power_good(port_power_good),
    .busy(port_settle_busy)
  );

  // Named views of the register file; slot is the offset less the first mapped one
  assign self_powered_max_power = regs_q[3'(`HPC_OFS_SP_MAX_POWER - `HPC_OFS_SP_MAX_POWER)];
  assign bus_powered_max_power = regs_q[3'(`HPC_OFS_BP_MAX_POWER - `HPC_OFS_SP_MAX_POWER)];
  assign self_powered_controller_current =
    regs_q[3'(`HPC_OFS_SP_CTRL_CURRENT - `HPC_OFS_SP_MAX_POWER)];
  assign bus_powered_controller_current =
    regs_q[3'(`HPC_OFS_BP_CTRL_CURRENT - `HPC_OFS_SP_MAX_POWER)];
  assign port_power_settle_time = regs_q[3'(`HPC_OFS_SETTLE_TIME - `HPC_OFS_SP_MAX_POWER)];
  assign language_code_upper = regs_q[3'(`HPC_OFS_LANG_UPPER - `HPC_OFS_SP_MAX_POWER)];
  assign language_code_lower = regs_q[3'(`HPC_OFS_LANG_LOWER - `HPC_OFS_SP_MAX_POWER)];
  assign maker_text_length = regs_q[3'(`HPC_OFS_TEXT_LENGTH - `HPC_OFS_SP_MAX_POWER)];

  // Length beyond the limit is not trusted; clamp for descriptor size
  assign clamped_len = (maker_text_length > `HPC_MAX_TEXT_CHARS) ? `HPC_MAX_TEXT_CHARS :
                       maker_text_length;

  // Mode pick; the strap only moves after its two sync flops, so no glitch reaches it
  assign sel_max_power = pin_sync2_q ? self_powered_max_power : bus_powered_max_power;
  assign sel_ctrl_current = pin_sync2_q ? self_powered_controller_current :
                            bus_powered_controller_current;

  // Upstream draw as reported, registered so it changes one edge after a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_power_units <= `HPC_RST_ZERO;
      max_power_ma <= 9'h000;
    end else begin
      max_power_units <= sel_max_power;
      max_power_ma <= units_to_ma(sel_max_power); // [RQ1] [RQ4]
    end
  end

  // Controller current alone; the writer leaves the compound peripheral out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_current_ma <= 9'h000;
    end else begin
      ctrl_current_ma <= units_to_ma(sel_ctrl_current); // [RQ5] [RQ7]
    end
  end

  // Descriptor copies of settle time, language code and text length
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_intervals <= `HPC_RST_ZERO;
      lang_code <= 16'h0000;
      text_length <= `HPC_RST_ZERO;
    end else begin
      settle_intervals <= port_power_settle_time; // [RQ8]
      lang_code <= {language_code_upper, language_code_lower}; // [RQ9]
      text_length <= maker_text_length;
    end
  end

  // Two bytes per character plus the header; at most 64
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      text_desc_length <= `HPC_DESC_HEADER_BYTES;
    end else begin
      text_desc_length <= 8'(`HPC_DESC_HEADER_BYTES + {clamped_len[6:0], 1'b0});
    end
  end

  // Software is trusted with the power limits, the text length is clamped; these flags only report a breach
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      text_length_over <= 1'b0;
      sp_power_over <= 1'b0;
    end else begin
      text_length_over <= maker_text_length > `HPC_MAX_TEXT_CHARS; // [RQ10]
      sp_power_over <= (self_powered_max_power > `HPC_MAX_UNITS_100MA) ||
                       (self_powered_controller_current > `HPC_MAX_UNITS_100MA); // [RQ3]
    end
  end

endmodule

`default_nettype wire

//--- testbench/hpc_power_string_props.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_power_string_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire hpc_pkg::hpc_byte_t cfg_addr,
  input wire hpc_pkg::hpc_byte_t cfg_wr_data,
  input wire logic cfg_rd_valid,
  input wire logic port_power_on,
  input wire logic port_power_off,
  input wire logic port_power_good,
  input wire logic port_settle_busy,
  input wire hpc_pkg::hpc_byte_t max_power_units,
  input wire logic [8:0] max_power_ma,
  input wire hpc_pkg::hpc_byte_t settle_intervals,
  input wire logic [15:0] lang_code,
  input wire hpc_pkg::hpc_byte_t text_length,
  input wire hpc_pkg::hpc_byte_t text_desc_length,
  input wire logic text_unit_valid,
  input wire logic [15:0] text_unit,
  input wire logic text_length_over
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Read answer comes exactly one cycle after the strobe
  rd_answer_a: assert property (cfg_rd_en |=> cfg_rd_valid) else $error("read not answered");
  rd_quiet_a: assert property (!cfg_rd_en |=> !cfg_rd_valid) else $error("stray read valid");
  // Milliamps always twice the selected 2 mA unit count
  ma_scale_a: assert property (max_power_ma == {max_power_units, 1'b0}) else $error("bad mA");
  lang_upper_a: assert property (cfg_wr_en && cfg_addr == 8'h11 |=> ##1
    lang_code[15:8] == $past(cfg_wr_data, 2)) else $error("language upper byte");
  lang_lower_a: assert property (cfg_wr_en && cfg_addr == 8'h12 |=> ##1
    lang_code[7:0] == $past(cfg_wr_data, 2)) else $error("language lower byte");
  settle_copy_a: assert property (cfg_wr_en && cfg_addr == 8'h10 |=> ##1
    settle_intervals == $past(cfg_wr_data, 2)) else $error("settle count copy");
  // Over-long length is clamped to 31 characters in the descriptor
  desc_len_a: assert property (text_desc_length == (text_length_over ? 8'h40 :
    8'h02 + {text_length[6:0], 1'b0})) else $error("descriptor length");
  len_over_a: assert property (text_length_over == (text_length > 8'h1F))
    else $error("length flag");
  unit_pair_a: assert property (cfg_wr_en && cfg_addr == 8'h16 ##1 cfg_wr_en && cfg_addr == 8'h17
    |=> ##1 text_unit_valid && text_unit == {$past(cfg_wr_data, 2), $past(cfg_wr_data, 3)})
    else $error("text unit order");
  power_off_a: assert property (port_power_off |=> !port_power_good && !port_settle_busy)
    else $error("power off ignored");
  cover_read_c: cover property (cfg_rd_valid);
  cover_unit_c: cover property (text_unit_valid);
  cover_good_c: cover property ($rose(port_power_good));
endmodule
`default_nettype wire

//--- testbench/hpc_cfg_loader.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_cfg_loader (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy,
  output logic wr_en,
  output logic [7:0] addr,
  output logic [7:0] data
);
  // Image rows: offset over value; limits kept by the writer
  localparam logic [15:0] IMG [10] = '{16'h0C32, 16'h0DFA, 16'h0E28, 16'h0F32, 16'h1003,
    16'h1104, 16'h1209, 16'h1301, 16'h1648, 16'h1700};
  logic [3:0] idx_q;
  // Back-to-back byte writes, one per cycle
  assign wr_en = busy;
  assign addr = IMG[idx_q][15:8];
  assign data = IMG[idx_q][7:0];
  // Walks the image once per start pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      idx_q <= 4'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      idx_q <= 4'h0;
    end else if (busy) begin
      busy <= idx_q != 4'h9;
      idx_q <= idx_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- testbench/hpc_power_string_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_power_string_regs_tb_top;
  logic core_clk = 1'b0, rst_b = 1'b0, t_wr = 1'b0, t_rd = 1'b0, ld_go = 1'b0;
  logic pin = 1'b0, pwr_on = 1'b0, pwr_off = 1'b0, ld_busy, ld_wr, wr_en, rd_valid, good, busy;
  logic [7:0] t_addr = 8'h00, t_data = 8'h00, ld_addr, ld_data, addr, wdata, rdata, units;
  logic [7:0] settle, tlen, dlen;
  logic [8:0] pwr_ma, ctl_ma;
  logic [15:0] lang, unit;
  logic [4:0] uidx;
  logic uval, beyond, perr, lover, spover, seen;
  int error_cnt = 0, cmp_count = 0, n;
  always #4 core_clk = ~core_clk;
  // Loader owns the port while it runs
  assign wr_en = ld_busy ? ld_wr : t_wr;
  assign addr = ld_busy ? ld_addr : t_addr;
  assign wdata = ld_busy ? ld_data : t_data;
  hpc_cfg_loader u_ld (.core_clk(core_clk), .rst_b(rst_b), .start(ld_go), .busy(ld_busy),
    .wr_en(ld_wr), .addr(ld_addr), .data(ld_data));
  hpc_power_string_regs #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .cfg_wr_en(wr_en), .cfg_rd_en(t_rd), .cfg_addr(addr), .cfg_wr_data(wdata),
    .cfg_rd_data(rdata), .cfg_rd_valid(rd_valid), .self_power_pin(pin),
    .port_power_on(pwr_on), .port_power_off(pwr_off), .port_power_good(good),
    .port_settle_busy(busy), .max_power_units(units), .max_power_ma(pwr_ma),
    .ctrl_current_ma(ctl_ma), .settle_intervals(settle), .lang_code(lang),
    .text_length(tlen), .text_desc_length(dlen), .text_unit_valid(uval), .text_unit(unit),
    .text_unit_index(uidx), .text_unit_beyond_len(beyond), .text_pair_error(perr),
    .text_length_over(lover), .sp_power_over(spover));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    t_wr <= 1'b1;
    t_addr <= a;
    t_data <= d;
    @(posedge core_clk);
    t_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    t_rd <= 1'b1;
    t_addr <= a;
    @(posedge core_clk);
    t_rd <= 1'b0;
    #1;
    chk("rd_valid", rd_valid, 1'b1);
    chk("rd_data", rdata, exp);
  endtask
  task automatic settle_wait();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Run is about a hundred cycles; this limit of 12500 cycles leaves wide margin
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int a = 8'h0C; a <= 8'h13; a++)
      rd(8'(a), (a == 8'h0E || a == 8'h0F) ? 8'h32 : 8'h00);
    chk("ctl_ma_rst", ctl_ma, 9'd100);
    wr(8'h05, 8'hA5);
    rd(8'h05, 8'h00);
    @(posedge core_clk);
    ld_go <= 1'b1;
    @(posedge core_clk);
    ld_go <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (ld_busy !== 1'b0 && n < 30);
    chk("load_done", ld_busy, 1'b0);
    settle_wait();
    chk("tlen", tlen, 8'h01);
    chk("beyond0", beyond, 1'b0);
    chk("bp_ma", pwr_ma, 9'd500);
    chk("bp_ctl", ctl_ma, 9'd100);
    chk("lang", lang, 16'h0409);
    chk("settle", settle, 8'h03);
    chk("desc_len", dlen, 8'h04);
    chk("unit", unit, 16'h0048);
    chk("unit_idx", uidx, 5'h00);
    pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk("sp_units", units, 8'h32);
    chk("sp_ma", pwr_ma, 9'd100);
    chk("sp_ctl", ctl_ma, 9'd80);
    chk("sp_over0", spover, 1'b0);
    wr(8'h0C, 8'h33);
    wr(8'h13, 8'h20);
    settle_wait();
    chk("sp_over1", spover, 1'b1);
    chk("len_over", lover, 1'b1);
    chk("desc_clamp", dlen, 8'h40);
    rd(8'h13, 8'h20);
    wr(8'h10, 8'h02);
    @(posedge core_clk);
    pwr_on <= 1'b1;
    @(posedge core_clk);
    pwr_on <= 1'b0;
    n = 0;
    while (good !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("settle_span", n >= 8 && n <= 12, 1'b1);
    @(posedge core_clk);
    pwr_off <= 1'b1;
    @(posedge core_clk);
    pwr_off <= 1'b0;
    settle_wait();
    chk("good_off", good, 1'b0);
    wr(8'h13, 8'h01);
    wr(8'h18, 8'h69);
    wr(8'h19, 8'h00);
    settle_wait();
    chk("unit2", unit, 16'h0069);
    chk("unit2_idx", uidx, 5'h01);
    chk("beyond1", beyond, 1'b1);
    wr(8'h19, 8'h55);
    seen = 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      seen |= perr;
    end
    chk("pair_err", seen, 1'b1);
    print_verdict();
  end
endmodule
bind hpc_power_string_regs hpc_power_string_props u_props (.core_clk(core_clk), .rst_b(rst_b),
  .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
  .cfg_wr_data(cfg_wr_data), .cfg_rd_valid(cfg_rd_valid), .port_power_on(port_power_on),
  .port_power_off(port_power_off), .port_power_good(port_power_good),
  .port_settle_busy(port_settle_busy), .max_power_units(max_power_units),
  .max_power_ma(max_power_ma), .settle_intervals(settle_intervals), .lang_code(lang_code),
  .text_length(text_length), .text_desc_length(text_desc_length),
  .text_unit_valid(text_unit_valid), .text_unit(text_unit), .text_length_over(text_length_over));
`default_nettype wire
